// ==== logic/gw_word_pkg.sv ====
package gw_word_pkg;
  // ----------------------------------------------------------------
  // area offsets and word layout
  // ----------------------------------------------------------------
  localparam logic [9:0] STATUS_OFFSET = 10'h000;
  localparam logic [9:0] CONTROL_OFFSET = 10'h200;
  localparam int BIT_HS_HI = 15;
  localparam int BIT_HS_LO = 14;
  localparam int BIT_VALID = 13;
  localparam int BIT_EXEC = 12;
  localparam int CODE_HI = 12;
  localparam int CODE_LO = 8;
  localparam int CMD_HI = 11;
  localparam int CMD_LO = 8;
  localparam int ARG_HI = 7;
  localparam int ARG_LO = 0;
  localparam int NODE_MAX = 32;
  localparam int NODE_AW = 5;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [NODE_MAX-1:0] NODES_RESET = '1;

  // ----------------------------------------------------------------
  // status codes, polling scan modes
  // ----------------------------------------------------------------
  localparam logic [4:0] ST_RETRY = 5'h00;
  localparam logic [4:0] ST_ONE_MISSING = 5'h01;
  localparam logic [4:0] ST_MANY_MISSING = 5'h02;
  localparam logic [4:0] ST_OVERRUN = 5'h03;
  localparam logic [4:0] ST_OTHER = 5'h04;
  localparam logic [4:0] ST_NO_ERROR = 5'h1F;
  // status codes, free frame mode
  localparam logic [4:0] FF_INVALID = 5'h00;
  localparam logic [4:0] FF_FRAME_ERR = 5'h01;
  localparam logic [4:0] FF_TIMEOUT = 5'h02;
  localparam logic [4:0] FF_OVERRUN = 5'h03;
  localparam logic [4:0] FF_OTHER = 5'h04;

  // ----------------------------------------------------------------
  // commands and modes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_DISABLE = 4'h0;
  localparam logic [3:0] CMD_ENABLE = 4'h1;
  localparam logic [3:0] CMD_ENABLE_N = 4'h2;

  typedef enum logic [1:0] {
    MODE_POLL = 2'b00,
    MODE_POLL_ALT = 2'b01,
    MODE_FREE = 2'b10
  } op_mode_e;

  typedef enum logic [1:0] {
    WORDS_OFF = 2'b00,
    WORDS_NO_LOCK = 2'b01,
    WORDS_LOCK = 2'b10
  } word_cfg_e;

  typedef enum logic [1:0] {
    LINK_OFFLINE = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_RUN = 2'b10
  } link_state_e;
endpackage

// ==== logic/gateway_status_control_word.sv ====
`timescale 1ns/1ps
// Summary of operation
// - status word at input bytes 0-1, bit15 send, bit14 confirm
// - polling modes: bit13 set once all transactions succeeded, sticky
// - free frame mode leaves status bit 13 at zero
// - latest status code in bits 12:8, argument byte in 7:0
// - words are big-endian, high byte at the lower address
// - polling: retransmission count grew gives warning 0x00 with count
// - polling: one node missing 0x01 address, several 0x02 count
// - polling: excess data warning 0x03, undefined fault error 0x04
// - after an error code, report 0x1F when the cause clears
// - free frame: invalid frame counter grew gives error 0x00
// - free frame: end character timeout gives warning 0x01
// - free frame: timed-out consume counter grew gives error 0x02
// - free frame: overrun warning 0x03, undefined fault error 0x04
// - control bit 13 high means outputs valid, low withholds exchange
// - control bit 13 honoured only in enabled-with-lock setting
// - control bit 12 executes command in 11:8 with argument 7:0
// - polling: command 0x00 disables node, 0x01 re-enables node
// - polling: command 0x02 enables first N nodes, disables rest
// - free frame mode takes no command action
// - with lock, no subnetwork exchange until control valid bit set
// - status valid bit clears only by going offline or by switching to free frame mode
// - words disabled by default, then occupy no area bytes
module gateway_status_control_word
  import gw_word_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration
  input wire logic [1:0] word_cfg,
  input wire logic [1:0] op_mode,
  // fieldbus area port: input area read, output area write
  input wire logic [9:0] area_addr,
  input wire logic area_wr,
  input wire logic [7:0] area_wdata,
  output logic [7:0] area_rdata,
  output logic words_active,
  // fieldbus and subnetwork state
  input wire logic fieldbus_online,
  input wire logic all_trans_done,
  // subnetwork events, one-cycle pulses with argument
  input wire logic ev_retry,
  input wire logic ev_missing,
  input wire logic [7:0] missing_count,
  input wire logic ev_overrun,
  input wire logic ev_other,
  input wire logic ev_invalid,
  input wire logic ev_frame_err,
  input wire logic ev_timeout,
  input wire logic ev_clear,
  input wire logic [7:0] ev_arg,
  // subnetwork control
  output logic exchange_en,
  output logic [NODE_MAX-1:0] node_enable
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic gw_handshake_toggle;
    logic gw_handshake_ack;
    logic data_valid;
    logic [4:0] code;
    logic [7:0] arg;
    logic err_pending;
    logic pend;
    logic [4:0] pend_code;
    logic [7:0] pend_arg;
    logic [NODE_MAX-1:0] nodes;
    link_state_e link;
    logic [7:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic enabled;
  logic polling;
  logic host_handshake_ack;
  logic host_handshake_toggle;
  logic host_valid;
  logic cmd_new;

  assign enabled = (word_cfg != WORDS_OFF);
  assign polling = (op_mode != MODE_FREE);
  assign host_handshake_ack = st_r.ctrl[BIT_HS_HI];
  assign host_handshake_toggle = st_r.ctrl[BIT_HS_LO];
  assign host_valid = st_r.ctrl[BIT_VALID];
  // new command seen when host send differs from our confirm
  assign cmd_new = (host_handshake_toggle != st_r.gw_handshake_ack);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] c;
    logic [7:0] a;
    logic hit;
    logic is_err;
    logic [15:0] sw;
    c = '0;
    a = '0;
    hit = 1'b0;
    is_err = 1'b0;
    sw = '0;
    st_nxt = st_r;

    // a command fires only on the high byte, which holds the send flag,
    // so a half-written word never starts one
    // host writes output area word, low byte first
    if (enabled && area_wr) begin
      if (area_addr == CONTROL_OFFSET) begin
        st_nxt.ctrl[15:8] = area_wdata;
      end else if (area_addr == CONTROL_OFFSET + 10'h001) begin
        st_nxt.ctrl[7:0] = area_wdata;
      end
    end

    // two edges from online to running: leave offline, then check lock
    // link participation; lock waits for the host valid bit
    case (st_r.link)
      LINK_OFFLINE: begin
        if (fieldbus_online) begin
          st_nxt.link = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (!fieldbus_online) begin
          st_nxt.link = LINK_OFFLINE;
        end else if (word_cfg != WORDS_LOCK || host_valid) begin
          st_nxt.link = LINK_RUN;
        end
      end
      LINK_RUN: begin
        if (!fieldbus_online) begin
          st_nxt.link = LINK_OFFLINE;
        end
      end
      default: st_nxt.link = LINK_OFFLINE;
    endcase

    // valid clears only by going offline or in free frame mode
    if (!fieldbus_online) begin
      st_nxt.data_valid = 1'b0;
    end else if (polling && all_trans_done && st_r.link == LINK_RUN) begin
      st_nxt.data_valid = 1'b1;
    end
    if (!polling) begin
      st_nxt.data_valid = 1'b0;
    end

    // event priority: errors first, then warnings, then clearance
    if (polling) begin
      if (ev_other) begin
        c = ST_OTHER; a = ev_arg; hit = 1'b1; is_err = 1'b1;
      end else if (ev_missing) begin
        hit = 1'b1;
        is_err = 1'b1;
        if (missing_count > 8'h01) begin
          c = ST_MANY_MISSING; a = missing_count;
        end else begin
          c = ST_ONE_MISSING; a = ev_arg;
        end
      end else if (ev_overrun) begin
        c = ST_OVERRUN; a = ev_arg; hit = 1'b1;
      end else if (ev_retry) begin
        c = ST_RETRY; a = ev_arg; hit = 1'b1;
      end
    end else begin
      if (ev_other) begin
        c = FF_OTHER; hit = 1'b1; is_err = 1'b1;
      end else if (ev_invalid) begin
        c = FF_INVALID; a = ev_arg; hit = 1'b1; is_err = 1'b1;
      end else if (ev_timeout) begin
        c = FF_TIMEOUT; a = ev_arg; hit = 1'b1; is_err = 1'b1;
      end else if (ev_overrun) begin
        c = FF_OVERRUN; hit = 1'b1;
      end else if (ev_frame_err) begin
        c = FF_FRAME_ERR; hit = 1'b1;
      end
    end
    // a clear in the same cycle as a new event is dropped: the event
    // is newer news and its cause is still live
    // no-error report once cause gone
    if (!hit && ev_clear && st_r.err_pending) begin
      c = ST_NO_ERROR; hit = 1'b1;
    end

    // newest report replaces any report not yet sent
    if (hit) begin
      st_nxt.pend = 1'b1;
      st_nxt.pend_code = c;
      st_nxt.pend_arg = a;
      if (is_err) begin
        st_nxt.err_pending = 1'b1;
      end else if (c == ST_NO_ERROR) begin
        st_nxt.err_pending = 1'b0;
      end
    end

    // holding a report until the host confirms loses none in transit,
    // at the cost that a burst of events shows only the newest
    // publish only when host confirmed last send
    if (enabled && st_r.pend
        && host_handshake_ack == st_r.gw_handshake_toggle) begin
      st_nxt.code = st_r.pend_code;
      st_nxt.arg = st_r.pend_arg;
      st_nxt.gw_handshake_toggle = ~st_r.gw_handshake_toggle;
      if (!hit) begin
        st_nxt.pend = 1'b0;
      end
    end

    // execute command on host send toggle
    if (enabled && cmd_new) begin
      st_nxt.gw_handshake_ack = host_handshake_toggle;
      if (polling && st_r.ctrl[BIT_EXEC]) begin
        case (st_r.ctrl[CMD_HI:CMD_LO])
          CMD_DISABLE: begin
            st_nxt.nodes[st_r.ctrl[NODE_AW-1:0]] = 1'b0;
          end
          CMD_ENABLE: begin
            st_nxt.nodes[st_r.ctrl[NODE_AW-1:0]] = 1'b1;
          end
          CMD_ENABLE_N: begin
            for (int i = 0; i < NODE_MAX; i++) begin
              st_nxt.nodes[i] = (i < int'(st_r.ctrl[ARG_HI:ARG_LO]));
            end
          end
          default: st_nxt.nodes = st_r.nodes;
        endcase
      end
    end

    // status word read, high byte first
    sw = {st_r.gw_handshake_toggle, st_r.gw_handshake_ack,
          st_r.data_valid, st_r.code, st_r.arg};
    st_nxt.rdata = 8'h00;
    if (enabled) begin
      if (area_addr == STATUS_OFFSET) begin
        st_nxt.rdata = sw[15:8];
      end else if (area_addr == STATUS_OFFSET + 10'h001) begin
        st_nxt.rdata = sw[7:0];
      end else if (area_addr == CONTROL_OFFSET) begin
        st_nxt.rdata = st_r.ctrl[15:8];
      end else if (area_addr == CONTROL_OFFSET + 10'h001) begin
        st_nxt.rdata = st_r.ctrl[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // code starts at no-error so the first read shows a clean word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{ctrl: WORD_RESET, code: ST_NO_ERROR,
                pend_code: ST_NO_ERROR, nodes: NODES_RESET,
                link: LINK_OFFLINE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign area_rdata = st_r.rdata;
  assign words_active = enabled;
  // under lock follows the live valid bit, so a host that drops it stops traffic
  // exchange only while running
  assign exchange_en = (st_r.link == LINK_RUN)
                       && (word_cfg != WORDS_LOCK || host_valid);
  assign node_enable = st_r.nodes;

endmodule

// ==== verif/gw_word_monitor.sv ====
`timescale 1ns/1ps
module gw_word_monitor
  import gw_word_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic [1:0] word_cfg,
  input wire logic [1:0] op_mode,
  input wire logic [9:0] area_addr,
  input wire logic area_wr,
  input wire logic [7:0] area_wdata,
  input wire logic [7:0] area_rdata,
  input wire logic words_active,
  input wire logic fieldbus_online,
  input wire logic exchange_en,
  input wire logic [NODE_MAX-1:0] node_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // mirror of the host valid bit, from taken writes only
  logic valid_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else if (area_wr && words_active && area_addr == CONTROL_OFFSET) begin
      valid_r <= area_wdata[BIT_VALID-8];
    end
  end
  sequence s_hi_wr;
    area_wr && words_active && area_addr == CONTROL_OFFSET;
  endsequence
  // read-back only counts while the words are still mapped
  sequence s_hi_rd;
    area_addr == CONTROL_OFFSET && !area_wr && words_active;
  endsequence
  sequence s_free_rd;
    (area_addr == STATUS_OFFSET && op_mode == MODE_FREE)[*2];
  endsequence
  AST_ACTIVE: assert property (
    words_active == (word_cfg != WORDS_OFF))
    else $error("words_active does not follow config");
  AST_OFF_READ: assert property (
    word_cfg == WORDS_OFF |=> area_rdata == 8'h00)
    else $error("disabled words still read nonzero");
  AST_ECHO: assert property (
    s_hi_wr ##1 s_hi_rd |=> area_rdata == $past(area_wdata, 2))
    else $error("control high byte not echoed");
  AST_LOCK_HOLD: assert property (
    word_cfg == WORDS_LOCK && !valid_r |-> !exchange_en)
    else $error("exchange before host valid");
  // the link needs two edges from online to running
  AST_LOCK_RUN: assert property (
    (word_cfg == WORDS_LOCK && valid_r && fieldbus_online)[*3]
    |-> exchange_en)
    else $error("exchange withheld with host valid");
  AST_NOLOCK: assert property (
    word_cfg != WORDS_LOCK && fieldbus_online |-> exchange_en)
    else $error("exchange withheld without lock");
  // the link state drops on the edge that sees the fieldbus go away
  AST_OFFLINE: assert property (
    !fieldbus_online |=> !exchange_en)
    else $error("exchange while offline");
  AST_FREE_BIT13: assert property (
    s_free_rd |=> !area_rdata[BIT_VALID-8])
    else $error("status bit 13 set in free frame mode");
  AST_FREE_CMD: assert property (
    (op_mode == MODE_FREE)[*3] |-> $stable(node_enable))
    else $error("node table changed in free frame mode");
endmodule
bind gateway_status_control_word gw_word_monitor mon (.core_clk(core_clk),
  .rst(rst), .word_cfg(word_cfg), .op_mode(op_mode), .area_addr(area_addr),
  .area_wr(area_wr), .area_wdata(area_wdata), .area_rdata(area_rdata),
  .words_active(words_active), .fieldbus_online(fieldbus_online),
  .exchange_en(exchange_en), .node_enable(node_enable));

// ==== verif/plc_model.sv ====
`timescale 1ns/1ps
module plc_model
  import gw_word_pkg::*;
(
  // clock
  input wire logic core_clk,
  // area bus toward the gateway
  output logic [9:0] area_addr,
  output logic area_wr,
  output logic [7:0] area_wdata,
  input wire logic [7:0] area_rdata
);
  logic [15:0] ctrl_w = 16'h0000;
  int gap = 0; // idle cycles per byte, for a slow host
  initial area_addr = CONTROL_OFFSET;
  initial area_wr = 1'b0;
  initial area_wdata = 8'h00;
  task automatic put_byte(input logic [9:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge core_clk);
    area_addr <= a;
    area_wr <= 1'b1;
    area_wdata <= d;
    @(posedge core_clk);
    area_wr <= 1'b0;
    area_wdata <= ~d; // stale data must not look valid
  endtask
  // high byte at the low address; low byte goes
  // first so a toggle never meets a stale argument
  task automatic put_ctrl(input logic [15:0] w);
    ctrl_w = w;
    put_byte(CONTROL_OFFSET + 10'h001, w[7:0]);
    put_byte(CONTROL_OFFSET, w[15:8]);
  endtask
  task automatic get_byte(input logic [9:0] a, output logic [7:0] d);
    @(posedge core_clk);
    area_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    d = area_rdata;
  endtask
  task automatic get_status(output logic [15:0] w);
    get_byte(STATUS_OFFSET, w[15:8]);
    get_byte(STATUS_OFFSET + 10'h001, w[7:0]);
  endtask
  // copy the gateway send flag into our confirm flag
  task automatic confirm();
    logic [15:0] st;
    get_status(st);
    put_ctrl({st[BIT_HS_HI], ctrl_w[14:0]});
  endtask
  // a new command toggles our send flag
  task automatic command(input logic ex, input logic [3:0] c,
                         input logic [7:0] a);
    logic [15:0] st;
    get_status(st);
    put_ctrl({ctrl_w[15], ~st[BIT_HS_LO], ctrl_w[13], ex, c, a});
  endtask
endmodule

// ==== verif/tb_gateway_status_control_word.sv ====
`timescale 1ns/1ps
module tb_gateway_status_control_word;
  import gw_word_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic [1:0] word_cfg = WORDS_LOCK;
  logic [1:0] op_mode = MODE_POLL;
  logic online = 1;
  logic done = 0;
  logic [7:0] ev = 0; // clear timeout frame invalid other overrun miss retry
  logic [7:0] cnt = 0;
  logic [7:0] arg = 0;
  logic [9:0] addr;
  logic wr, act, xen, tg;
  logic [7:0] wd, rd;
  logic [15:0] st;
  logic [31:0] nodes, exp_n;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  gateway_status_control_word dut (.core_clk(core_clk), .rst(rst),
    .word_cfg(word_cfg), .op_mode(op_mode), .area_addr(addr), .area_wr(wr),
    .area_wdata(wd), .area_rdata(rd), .words_active(act),
    .fieldbus_online(online), .all_trans_done(done), .ev_retry(ev[0]),
    .ev_missing(ev[1]), .missing_count(cnt), .ev_overrun(ev[2]),
    .ev_other(ev[3]), .ev_invalid(ev[4]), .ev_frame_err(ev[5]),
    .ev_timeout(ev[6]), .ev_clear(ev[7]), .ev_arg(arg),
    .exchange_en(xen), .node_enable(nodes));
  plc_model plc (.core_clk(core_clk), .area_addr(addr), .area_wr(wr),
    .area_wdata(wd), .area_rdata(rd));
  always #25 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // argument: node count for several missing, else the event argument
  function automatic logic [7:0] exp_arg(input logic [7:0] a, c);
    return (c > 8'h01) ? c : a;
  endfunction
  function automatic logic [31:0] first_n(input int k);
    return 32'((33'h1 << k) - 33'h1);
  endfunction
  task automatic fire(input int b, input logic [4:0] code,
                      input logic [7:0] c, input logic chk_arg);
    logic [7:0] a;
    a = 8'($urandom);
    @(posedge core_clk);
    ev <= 8'h01 << b;
    arg <= a;
    cnt <= c;
    @(posedge core_clk);
    ev <= 8'h00;
    plc.get_status(st);
    tg = ~tg;
    check("send flag", st[BIT_HS_HI], tg);
    check("code", st[CODE_HI:CODE_LO], code);
    if (chk_arg) check("arg", st[ARG_HI:ARG_LO], exp_arg(a, c));
    plc.confirm();
  endtask
  task automatic do_cmd(input logic ex, input logic [3:0] c, input int a);
    plc.command(ex, c, 8'(a));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("nodes", nodes, exp_n);
    plc.get_status(st);
    check("ack", st[BIT_HS_LO], plc.ctrl_w[14]);
  endtask
  initial begin
    void'($urandom(70));
    tg = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("nodes", nodes, NODES_RESET);
    check("exchange", xen, 1'b0);
    plc.get_status(st);
    check("status", st, {3'b000, ST_NO_ERROR, 8'h00});
    check("valid", st[BIT_VALID], 1'b0);
    plc.put_ctrl(16'h2000);
    // the lock releases one edge after the valid bit lands
    @(posedge core_clk);
    done <= 1'b1;
    @(negedge core_clk);
    check("exchange", xen, 1'b1);
    plc.get_status(st);
    check("valid", st[BIT_VALID], 1'b1);
    done <= 1'b0;
    plc.get_status(st);
    check("valid", st[BIT_VALID], 1'b1);
    $display("test startup done");
    fire(0, 5'h00, 8'h00, 1);
    fire(1, 5'h01, 8'h01, 1);
    fire(1, 5'h02, 8'(2 + $urandom % 254), 1);
    fire(2, 5'h03, 8'h00, 1);
    fire(3, 5'h04, 8'h00, 1);
    fire(7, 5'h1F, 8'h00, 0);
    $display("test polling codes done");
    // commands run in the second polling mode
    op_mode <= MODE_POLL_ALT;
    n = 1 + $urandom % 31;
    exp_n = first_n(n);
    do_cmd(1, CMD_ENABLE_N, n);
    n = $urandom % n;
    exp_n[n] = 1'b0;
    do_cmd(1, CMD_DISABLE, n);
    do_cmd(0, CMD_ENABLE, n);
    exp_n[n] = 1'b1;
    do_cmd(1, CMD_ENABLE, n);
    exp_n = '1;
    do_cmd(1, CMD_ENABLE_N, 32);
    $display("test commands done");
    // slow host from here on
    plc.gap = 2;
    op_mode <= MODE_FREE;
    plc.get_status(st);
    check("valid", st[BIT_VALID], 1'b0);
    fire(4, 5'h00, 8'h00, 1);
    fire(5, 5'h01, 8'h00, 0);
    fire(6, 5'h02, 8'h00, 1);
    fire(2, 5'h03, 8'h00, 0);
    fire(3, 5'h04, 8'h00, 0);
    fire(7, 5'h1F, 8'h00, 0);
    do_cmd(1, CMD_ENABLE_N, 3);
    $display("test free frame done");
    word_cfg <= WORDS_NO_LOCK;
    plc.put_ctrl({plc.ctrl_w[15:14], 14'h0000});
    @(negedge core_clk);
    check("exchange", xen, 1'b1);
    online <= 1'b0;
    word_cfg <= WORDS_OFF;
    plc.get_byte(STATUS_OFFSET, st[7:0]);
    check("exchange", xen, 1'b0);
    check("area", {act, st[7:0]}, 9'h000);
    $display("test config done");
    results();
  end
endmodule
